// file: vcspg_params.svh
`ifndef VCSPG_PARAMS_SVH
`define VCSPG_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define VCSPG_ADDR_CTRL 12'h000
`define VCSPG_ADDR_SUSCODE 12'h004
`define VCSPG_ADDR_STATUS 12'h008
`define VCSPG_ADDR_SAMPLE 12'h00c

// ****************************************
// field positions
// ****************************************
`define VCSPG_CTRL_FORCE_SAMPLE 0
`define VCSPG_ST_PGOOD 0
`define VCSPG_ST_SHUTDOWN 1
`define VCSPG_ST_OVP_EN 2
`define VCSPG_ST_UVP_EN 3
`define VCSPG_ST_BLANK 4
`define VCSPG_ST_SLEWING 5
`define VCSPG_ST_SRC_LSB 6
`define VCSPG_ST_DAC_LSB 8

// ****************************************
// reset values and timing
// ****************************************
`define VCSPG_SUSCODE_RST 32'h0000_0000
`define VCSPG_VID_RST 5'h00
`define VCSPG_CLK_HZ 40000000
`define VCSPG_SLEW_HZ 150000
`define VCSPG_SLEW_DIV (`VCSPG_CLK_HZ / `VCSPG_SLEW_HZ)

`endif

// file: vcspg_pkg.sv
package vcspg_pkg;
   typedef logic [4:0] vcspg_vid_t;
   typedef enum logic [1:0] {VCSPG_SRC_SUS, VCSPG_SRC_LOGIC, VCSPG_SRC_IMP} vcspg_src_t;
   typedef enum logic [1:0] {VCSPG_PG_IDLE, VCSPG_PG_SLEW, VCSPG_PG_HOLD} vcspg_pg_t;
endpackage : vcspg_pkg

// file: vcspg_slew_tick.sv
`timescale 1ns/1ps
`include "vcspg_params.svh"
// ****************************************
// slew-rate clock tick generator
// ****************************************
module vcspg_slew_tick
   import vcspg_pkg::*;
#(
   parameter int DIV = `VCSPG_SLEW_DIV
) (
   input wire logic mclk,
   input wire logic rst_n,
   output logic tick
);
   logic [15:0] cnt_ff;
   wire logic atEnd = (cnt_ff == 16'(DIV - 1));
   wire logic [15:0] nxt_cnt = atEnd ? 16'h0000 : cnt_ff + 16'h0001;

   // free-running divider
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 16'h0000;
         tick <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         tick <= atEnd;
      end
   end
endmodule : vcspg_slew_tick

// file: vcspg_top.sv
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "vcspg_params.svh"
// How it works
// - suspend select high routes suspend code
// - mux select low passes logic code
// - qualifying events trigger impedance code sampling
// - impedance comparator gives low/high per bit
// - five-bit code, input 0 is LSB
// - out-of-window feedback pulls power good low
// - power good held through slew plus one tick
// - power good low during shutdown
// - protect enable input is active low
// - undervoltage and thermal ignore protect input
// - shutdown request high means shutdown; skip high voltage is a separate input
// - slew clock period is a parameter
// - high voltage skip disables over/undervoltage protection, clears fault unless thermal
module vcspg_top
   import vcspg_pkg::*;
#(
   parameter int SLEW_DIV = `VCSPG_SLEW_DIV
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic suspend_select,
   input wire logic performance_mux_select,
   input wire logic [4:0] vid_code_inputs,
   input wire logic [4:0] vid_code_impedance_high,
   input wire logic [1:0] suspend_level_select_0,
   input wire logic [1:0] suspend_level_select_1,
   input wire logic overvoltage_protect_enable_n,
   input wire logic shutdown_request,
   input wire logic skip_high_voltage,
   input wire logic feedback_in_window,
   input wire logic overvoltage_detect,
   input wire logic undervoltage_detect,
   input wire logic thermal_detect,
   input wire logic slew_busy,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [4:0] dac_code,
   output logic power_good_out,
   output logic power_good_oe,
   output logic overvoltage_protect_active,
   output logic undervoltage_protect_active,
   output logic fault_latched
);

   // ****************************************
   // slew clock
   // ****************************************
   logic slewTick;
   vcspg_slew_tick #(.DIV(SLEW_DIV)) u_tick (
      .mclk(mclk),
      .rst_n(rst_n),
      .tick(slewTick)
   );

   // ****************************************
   // bus registers
   // ****************************************
   logic [31:0] susTable_ff;
   logic forceSample_ff;
   logic awHeld_ff;
   logic wHeld_ff;
   logic [11:0] awAddr_ff;
   logic [31:0] wData_ff;
   logic [3:0] wStrb_ff;

   // write channel capture, either order
   assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_ff && !s_axi_bvalid;
   wire logic awTake = s_axi_awvalid && s_axi_awready;
   wire logic wTake = s_axi_wvalid && s_axi_wready;
   wire logic haveAw = awHeld_ff || awTake;
   wire logic haveW = wHeld_ff || wTake;
   wire logic doWrite = haveAw && haveW && !s_axi_bvalid;
   wire logic [11:0] wrAddr = awHeld_ff ? awAddr_ff : s_axi_awaddr;
   wire logic [31:0] wrData = wHeld_ff ? wData_ff : s_axi_wdata;
   wire logic [3:0] wrStrb = wHeld_ff ? wStrb_ff : s_axi_wstrb;
   wire logic wrCtrl = (wrAddr == `VCSPG_ADDR_CTRL);
   wire logic wrSus = (wrAddr == `VCSPG_ADDR_SUSCODE);
   wire logic wrOk = wrCtrl || wrSus || (wrAddr == `VCSPG_ADDR_STATUS)
      || (wrAddr == `VCSPG_ADDR_SAMPLE);

   // byte-lane merge
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   wire logic [31:0] nxt_susTable = merge(susTable_ff, wrData, wrStrb);
   wire logic nxt_force = doWrite && wrCtrl && wrStrb[0] && wrData[`VCSPG_CTRL_FORCE_SAMPLE];

   // write path state
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld_ff <= 1'b0;
         wHeld_ff <= 1'b0;
         awAddr_ff <= 12'h000;
         wData_ff <= 32'h0000_0000;
         wStrb_ff <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         susTable_ff <= `VCSPG_SUSCODE_RST;
         forceSample_ff <= 1'b0;
      end else begin
         forceSample_ff <= nxt_force;
         if (doWrite) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrOk ? 2'b00 : 2'b10;
            if (wrSus) begin
               susTable_ff <= nxt_susTable;
            end
         end else begin
            if (awTake) begin
               awHeld_ff <= 1'b1;
               awAddr_ff <= s_axi_awaddr;
            end
            if (wTake) begin
               wHeld_ff <= 1'b1;
               wData_ff <= s_axi_wdata;
               wStrb_ff <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
               s_axi_bvalid <= 1'b0;
            end
         end
      end
   end

   // ****************************************
   // code selection
   // ****************************************
   logic susPrev_ff;
   logic zPrev_ff;
   logic powerUp_ff;
   vcspg_vid_t impCode_ff;
   vcspg_src_t src_ff;
   vcspg_vid_t dacCode_ff;
   logic faultLatch_ff;

   wire logic inShutdown = shutdown_request;
   // four levels per select, but only bit 0 of select 1 is used: 8 suspend codes, 2 held per byte lane
   wire logic [3:0] susIndex = {suspend_level_select_1, suspend_level_select_0};
   wire logic [1:0] susWord = susIndex[3:2];
   wire logic [1:0] susByte = susIndex[1:0];
   wire logic [7:0] susLane = susTable_ff[{susByte, 3'b000} +: 8];
   wire vcspg_vid_t susCode = susWord[0] ? susLane[7:3] ^ susLane[4:0] : susLane[4:0];
   // impedance comparator result: high means near or above 100k, low near or below 1k
   wire vcspg_vid_t sampledCode = vid_code_impedance_high;
   wire logic zRise = performance_mux_select && !zPrev_ff;
   wire logic susFall = !suspend_select && susPrev_ff && performance_mux_select;
   wire logic startSample = powerUp_ff && performance_mux_select;
   wire logic doSample = zRise || susFall || startSample || forceSample_ff;
   wire vcspg_src_t nxt_src = suspend_select ? VCSPG_SRC_SUS
      : (performance_mux_select ? VCSPG_SRC_IMP : VCSPG_SRC_LOGIC);
   wire vcspg_vid_t nxt_imp = doSample ? sampledCode : impCode_ff;
   wire vcspg_vid_t nxt_dac = (nxt_src == VCSPG_SRC_SUS) ? susCode
      : (nxt_src == VCSPG_SRC_LOGIC) ? vid_code_inputs : nxt_imp;

   // source select and latched sample
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         susPrev_ff <= 1'b0;
         zPrev_ff <= 1'b0;
         powerUp_ff <= 1'b1;
         impCode_ff <= `VCSPG_VID_RST;
         src_ff <= VCSPG_SRC_LOGIC;
         dacCode_ff <= `VCSPG_VID_RST;
      end else begin
         susPrev_ff <= suspend_select;
         zPrev_ff <= performance_mux_select;
         powerUp_ff <= 1'b0;
         impCode_ff <= nxt_imp;
         src_ff <= nxt_src;
         dacCode_ff <= nxt_dac;
      end
   end
   assign dac_code = dacCode_ff;

   // ****************************************
   // power good blanking
   // ****************************************
   vcspg_pg_t pg_ff;
   vcspg_pg_t nxt_pg;
   logic pgOut_ff;
   wire logic codeChange = (nxt_dac != dacCode_ff);

   // blanking state machine
   always_comb begin
      nxt_pg = pg_ff;
      unique case (pg_ff)
         VCSPG_PG_IDLE: begin
            if (codeChange || slew_busy) begin
               nxt_pg = VCSPG_PG_SLEW;
            end
         end
         VCSPG_PG_SLEW: begin
            if (!slew_busy && !codeChange) begin
               nxt_pg = VCSPG_PG_HOLD;
            end
         end
         VCSPG_PG_HOLD: begin
            if (codeChange || slew_busy) begin
               nxt_pg = VCSPG_PG_SLEW;
            end else if (slewTick) begin
               nxt_pg = VCSPG_PG_IDLE;
            end
         end
      endcase
      if (inShutdown) begin
         nxt_pg = VCSPG_PG_IDLE;
      end
   end

   wire logic blanking = (nxt_pg != VCSPG_PG_IDLE);
   wire logic nxt_pgOut = !inShutdown && (blanking || feedback_in_window);

   // power good register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pg_ff <= VCSPG_PG_IDLE;
         pgOut_ff <= 1'b0;
      end else begin
         pg_ff <= nxt_pg;
         pgOut_ff <= nxt_pgOut;
      end
   end
   // open drain: driven only when low
   assign power_good_out = 1'b0;
   assign power_good_oe = !pgOut_ff;

   // ****************************************
   // protection
   // ****************************************
   wire logic ovpOn = !overvoltage_protect_enable_n && !skip_high_voltage;
   wire logic uvpOn = !skip_high_voltage;
   wire logic tripNow = (ovpOn && overvoltage_detect) || (uvpOn && undervoltage_detect)
      || thermal_detect;

   // fault latch
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         faultLatch_ff <= 1'b0;
      end else if (skip_high_voltage) begin
         faultLatch_ff <= thermal_detect;
      end else if (tripNow) begin
         faultLatch_ff <= 1'b1;
      end
   end
   assign overvoltage_protect_active = ovpOn;
   assign undervoltage_protect_active = uvpOn;
   assign fault_latched = faultLatch_ff;

   // ****************************************
   // read path
   // ****************************************
   wire logic [31:0] statusWord = {18'h00000, dacCode_ff, 1'b0, src_ff, slew_busy,
      (pg_ff != VCSPG_PG_IDLE), uvpOn, ovpOn, inShutdown, pgOut_ff};
   wire logic [31:0] rdMux = (s_axi_araddr == `VCSPG_ADDR_CTRL) ? 32'h0000_0000
      : (s_axi_araddr == `VCSPG_ADDR_SUSCODE) ? susTable_ff
      : (s_axi_araddr == `VCSPG_ADDR_STATUS) ? statusWord
      : {27'h0000000, impCode_ff};
   wire logic rdOk = (s_axi_araddr == `VCSPG_ADDR_CTRL) || (s_axi_araddr == `VCSPG_ADDR_SUSCODE)
      || (s_axi_araddr == `VCSPG_ADDR_STATUS) || (s_axi_araddr == `VCSPG_ADDR_SAMPLE);
   assign s_axi_arready = !s_axi_rvalid;

   // read response
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdOk ? rdMux : 32'h0000_0000;
         s_axi_rresp <= rdOk ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : vcspg_top

// file: vcspg_assertions.sv
`timescale 1ns/1ps
module vcspg_checker
   import vcspg_pkg::*;
#(
   parameter int SLEW_DIV = 4
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic suspend_select,
   input wire logic performance_mux_select,
   input wire logic [4:0] vid_code_inputs,
   input wire logic [4:0] vid_code_impedance_high,
   input wire logic [1:0] suspend_level_select_0,
   input wire logic [1:0] suspend_level_select_1,
   input wire logic overvoltage_protect_enable_n,
   input wire logic shutdown_request,
   input wire logic skip_high_voltage,
   input wire logic feedback_in_window,
   input wire logic thermal_detect,
   input wire logic slew_busy,
   input wire logic s_axi_wvalid,
   input wire logic [4:0] dac_code,
   input wire logic power_good_oe,
   input wire logic overvoltage_protect_active,
   input wire logic undervoltage_protect_active,
   input wire logic fault_latched
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // code source selection
   a_logic_route: assert property (!suspend_select && !performance_mux_select
      |=> dac_code == $past(vid_code_inputs)) else $error("logic code not routed");
   a_sus_override: assert property (suspend_select && $past(suspend_select)
      && $stable(suspend_level_select_0) && $stable(suspend_level_select_1)
      && !s_axi_wvalid && !$past(s_axi_wvalid) |=> $stable(dac_code))
      else $error("suspend code not held");
   a_imp_take: assert property ($rose(performance_mux_select) && !suspend_select
      ##1 (performance_mux_select && !suspend_select && $stable(vid_code_impedance_high))[*2]
      |-> dac_code == vid_code_impedance_high) else $error("impedance code not taken");
   a_imp_hold: assert property ((!suspend_select && performance_mux_select
      && !s_axi_wvalid)[*3] |=> $stable(dac_code)) else $error("sampled code moved");
   // power good pin
   a_shut_low: assert property (shutdown_request |=> power_good_oe)
      else $error("pin not low in shutdown");
   a_win_high: assert property (feedback_in_window && !shutdown_request
      |=> !power_good_oe) else $error("pin low in regulation");
   a_win_low: assert property ((!feedback_in_window && !slew_busy && !shutdown_request
      && $stable(dac_code))[*8] |=> power_good_oe) else $error("pin not low out of window");
   a_slew_hold: assert property (slew_busy && !shutdown_request |=> !power_good_oe)
      else $error("pin not held while slewing");
   // protection controls
   a_ovp_map: assert property (overvoltage_protect_active ==
      (!overvoltage_protect_enable_n && !skip_high_voltage)) else $error("ovp enable wrong");
   a_uvp_keep: assert property (!skip_high_voltage |-> undervoltage_protect_active)
      else $error("uvp dropped");
   a_skip_clear: assert property (skip_high_voltage && !thermal_detect
      |=> !fault_latched) else $error("fault not cleared");
endmodule : vcspg_checker

bind vcspg_top vcspg_checker #(.SLEW_DIV(SLEW_DIV)) vcspg_checker_i (.*);

// file: vcspg_sysctl_model.sv
`timescale 1ns/1ps
// system controller: drives the select and code pins
module vcspg_sysctl_model (
   input wire logic susUsed,
   input wire logic susReq,
   input wire logic perfReq,
   input wire logic [4:0] codeReq,
   input wire logic [4:0] impReq,
   input wire logic [1:0] lvlReq,
   input wire logic [1:0] lvlHiReq,
   output logic suspend_select,
   output logic performance_mux_select,
   output logic [4:0] vid_code_inputs,
   output logic [4:0] vid_code_impedance_high,
   output logic [1:0] suspend_level_select_0,
   output logic [1:0] suspend_level_select_1
);
   // pins follow requests, which change just after an edge
   assign suspend_select = susUsed & susReq;
   assign performance_mux_select = perfReq;
   assign vid_code_inputs = codeReq;
   assign vid_code_impedance_high = impReq;
   assign suspend_level_select_0 = lvlReq;
   assign suspend_level_select_1 = lvlHiReq;
endmodule : vcspg_sysctl_model

// file: tb_vid_code_select_and_power_good.sv
`timescale 1ns/1ps
`include "vcspg_params.svh"
module tb_vid_code_select_and_power_good
   import vcspg_pkg::*;
;
   localparam int SDIV = 4;
   logic mclk = 1'b0, rst_n = 1'b0;
   logic susUsed = 1'b0, susReq = 1'b0, perfReq = 1'b0;
   logic [4:0] codeReq = 5'h00, impReq = 5'h00, impLat = 5'h00;
   logic [1:0] lvlReq = 2'h0;
   logic [1:0] lvlHiReq = 2'h0;
   wire logic suspend_select, performance_mux_select;
   wire logic [4:0] vid_code_inputs, vid_code_impedance_high;
   wire logic [1:0] suspend_level_select_0, suspend_level_select_1;
   logic overvoltage_protect_enable_n = 1'b0, shutdown_request = 1'b0;
   logic skip_high_voltage = 1'b0, feedback_in_window = 1'b1, overvoltage_detect = 1'b0;
   logic undervoltage_detect = 1'b0, thermal_detect = 1'b0, slew_busy = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, susWord = 32'h0, rd, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [4:0] dac_code;
   logic power_good_out, power_good_oe, overvoltage_protect_active;
   logic undervoltage_protect_active, fault_latched;
   logic [15:0] lfsr = 16'h003f;
   int n_fail = 0, compares = 0;
   vcspg_top #(.SLEW_DIV(SDIV)) vcspg_top_i (.*);
   vcspg_sysctl_model vcspg_sysctl_model_i (.*);
   // clock and watchdog
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      end_of_test();
   end
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
   endtask : cyc
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // random source, shifted once per draw
   function automatic logic [15:0] lfsrNext(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsrNext
   // behavioural reference of the selected code
   function automatic logic [4:0] expDac();
      logic [7:0] lane;
      lane = susWord[8*lvlReq +: 8];
      if (susUsed && susReq) return lvlHiReq[0] ? lane[7:3] ^ lane[4:0] : lane[4:0];
      if (!perfReq) return codeReq;
      return impLat;
   endfunction : expDac
   // handshakes judged on values settled at the falling edge before the edge
   task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic awRdy, wRdy, bSeen;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge mclk);
         awRdy = s_axi_awready;
         wRdy = s_axi_wready;
         bSeen = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge mclk);
         if (awRdy) s_axi_awvalid <= 1'b0;
         if (wRdy) s_axi_wvalid <= 1'b0;
      end while (!bSeen);
      s_axi_bready <= 1'b0;
      @(posedge mclk);
   endtask : axw
   task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic arRdy, rSeen;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge mclk);
         arRdy = s_axi_arready;
         rSeen = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge mclk);
         if (arRdy) s_axi_arvalid <= 1'b0;
      end while (!rSeen);
      s_axi_rready <= 1'b0;
      @(posedge mclk);
   endtask : axr
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   // main sequence
   initial begin
      cyc(20);
      rst_n <= 1'b1;
      cyc(2);
      axr(`VCSPG_ADDR_SUSCODE, rd, rsp);
      chk("suscode", rd, `VCSPG_SUSCODE_RST);
      axr(12'h010, rd, rsp);
      chk("rresp", rsp, 2'h2);
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsrNext(lfsr);
         codeReq <= lfsr[4:0];
         cyc(3);
         chk("dac logic", dac_code, expDac());
      end
      $display("logic code test done");
      axw(`VCSPG_ADDR_SUSCODE, 32'h1f0a_1503, rsp);
      chk("bresp sus", rsp, 2'h0);
      susWord = 32'h1f0a_1503;
      susUsed <= 1'b1;
      susReq <= 1'b1;
      perfReq <= 1'b1;
      impReq <= 5'h15;
      for (int i = 0; i < 4; i++) begin
         lvlReq <= i[1:0];
         cyc(3);
         chk("dac sus", dac_code, expDac());
      end
      lvlHiReq <= 2'h1;
      cyc(3);
      chk("dac sus alt", dac_code, expDac());
      lvlHiReq <= 2'h0;
      susReq <= 1'b0;
      impLat = 5'h15;
      cyc(3);
      chk("dac sus fall", dac_code, expDac());
      impReq <= 5'h0a;
      codeReq <= 5'h1f;
      cyc(4);
      chk("dac held", dac_code, expDac());
      perfReq <= 1'b0;
      cyc(3);
      chk("dac back", dac_code, expDac());
      perfReq <= 1'b1;
      impLat = 5'h0a;
      cyc(3);
      chk("dac rise", dac_code, expDac());
      lfsr = lfsrNext(lfsr);
      impReq <= lfsr[4:0] | 5'h10;
      cyc(3);
      chk("dac no force", dac_code, expDac());
      axw(`VCSPG_ADDR_CTRL, 32'h0000_0001, rsp);
      chk("bresp ctrl", rsp, 2'h0);
      impLat = impReq;
      cyc(2);
      chk("dac force", dac_code, expDac());
      axr(`VCSPG_ADDR_SAMPLE, rd, rsp);
      chk("sample reg", rd, {27'h0000000, impLat});
      axr(`VCSPG_ADDR_STATUS, rd, rsp);
      chk("status dac", rd[13:9], impLat);
      chk("status src", rd[7:6], 2'h2);
      axw(12'h010, 32'h0000_0000, rsp);
      chk("bresp bad", rsp, 2'h2);
      $display("code source test done");
      feedback_in_window <= 1'b0;
      cyc(10);
      chk("pg oe out", power_good_oe, 1'b1);
      chk("pg pin", power_good_out, 1'b0);
      slew_busy <= 1'b1;
      cyc(3);
      chk("pg oe slew", power_good_oe, 1'b0);
      slew_busy <= 1'b0;
      cyc(SDIV + 3);
      chk("pg oe after", power_good_oe, 1'b1);
      feedback_in_window <= 1'b1;
      cyc(2);
      chk("pg oe in", power_good_oe, 1'b0);
      shutdown_request <= 1'b1;
      slew_busy <= 1'b1;
      cyc(3);
      chk("pg oe shut", power_good_oe, 1'b1);
      shutdown_request <= 1'b0;
      slew_busy <= 1'b0;
      cyc(SDIV + 3);
      $display("power good test done");
      for (int i = 0; i < 4; i++) begin
         {skip_high_voltage, overvoltage_protect_enable_n} <= i[1:0];
         cyc(2);
         chk("ovp", overvoltage_protect_active, i == 0);
         chk("uvp", undervoltage_protect_active, i < 2);
      end
      {skip_high_voltage, overvoltage_protect_enable_n} <= 2'h1;
      overvoltage_detect <= 1'b1;
      cyc(3);
      chk("fault ovp off", fault_latched, 1'b0);
      overvoltage_detect <= 1'b0;
      undervoltage_detect <= 1'b1;
      cyc(3);
      undervoltage_detect <= 1'b0;
      cyc(3);
      chk("fault uvp", fault_latched, 1'b1);
      skip_high_voltage <= 1'b1;
      cyc(3);
      chk("fault clear", fault_latched, 1'b0);
      thermal_detect <= 1'b1;
      cyc(3);
      chk("fault thermal", fault_latched, 1'b1);
      thermal_detect <= 1'b0;
      $display("protection test done");
      end_of_test();
   end
endmodule : tb_vid_code_select_and_power_good
